// ### rwf_consts.vh
// constants for the reading word formatter
`ifndef RWF_CONSTS_VH
`define RWF_CONSTS_VH
`define RWF_WORD_W        16
`define RWF_ADDR_W        3
`define RWF_ADDR_IDENT    3'h0
`define RWF_ADDR_STATUS   3'h1
`define RWF_ADDR_DATA     3'h4
`define RWF_MODE_13       2'h0
`define RWF_MODE_14       2'h1
`define RWF_MODE_16       2'h2
`define RWF_MODE_BAD      2'h3
`define RWF_GOOD_BIT      15
`define RWF_R13_RANGE_HI  14
`define RWF_R13_RANGE_LO  13
`define RWF_R13_SIGN_BIT  12
`define RWF_R13_MAG_HI    11
`define RWF_R13_OVL       12'hFFF
`define RWF_R14_RANGE_HI  15
`define RWF_R14_RANGE_LO  14
`define RWF_R14_VAL_HI    13
`define RWF_R14_POS_OVL   14'h1FFF
`define RWF_R14_NEG_OVL   14'h2000
`define RWF_R16_POS_OVL   16'h7FFF
`define RWF_R16_NEG_OVL   16'h8000
`define RWF_ST_RANGE_LO   8
`define RWF_ST_AVAIL_BIT  6
`define RWF_ZERO_WORD     16'h0000
`define RWF_HS_IDLE       2'h0
`define RWF_HS_HOLD       2'h1
`define RWF_HS_WAIT       2'h2
`endif

// ### rwf_fmt_asserts.sv
// port checker for the reading word formatter
`timescale 1ns/1ps
`default_nettype none
module rwf_fmt_asserts #(
  parameter [15:0] IDENT_WORD = 16'h0040
) (
  input wire logic        sys_clk,
  input wire logic        srst,
  input wire logic        slot_register_read_command,
  input wire logic [2:0]  cmdRegAddr,
  input wire logic [15:0] cmdReadData,
  input wire logic        cmdReadDone,
  input wire logic [1:0]  rangeCode,
  input wire logic        resetCmd,
  input wire logic        resolSet,
  input wire logic [1:0]  resolCode,
  input wire logic [1:0]  resolMode,
  input wire logic        hostReq,
  input wire logic        hostAck
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (srst);
  wire logic cmd = slot_register_read_command;
  AST_DONE_ONE: assert property (cmdReadDone && !cmd |=> !cmdReadDone) else $error("long done");
  AST_CMD_ANS: assert property (cmd && cmdRegAddr != 3'h4 |=> cmdReadDone) else $error("no answer");
  AST_IDENT: assert property (cmd && cmdRegAddr == 3'h0 |=> cmdReadData == IDENT_WORD) else $error("ident");
  AST_STATUS: assert property (cmd && cmdRegAddr == 3'h1 |=> cmdReadData[9:8] == $past(rangeCode))
    else $error("status range");
  AST_RSTCMD: assert property (resetCmd && !resolSet |=> resolMode == 2'h0) else $error("mode reset");
  AST_RESOL: assert property (resolSet && resolCode != 2'h3 && !resetCmd |=> resolMode == $past(resolCode))
    else $error("mode set");
  AST_ACK_UP: assert property ($rose(hostAck) |-> $past(hostReq)) else $error("ack without request");
  AST_ACK_DOWN: assert property ($fell(hostReq) |-> ##[1:5] !hostAck) else $error("ack stuck");
endmodule
`default_nettype wire

// ### rwf_host_model.sv
// parallel port host model
`timescale 1ns/1ps
`default_nettype none
module rwf_host_model (
  input  wire logic        sys_clk,
  output var  logic        address_phase_strobe,
  output var  logic        hostReq,
  output var  logic        hostRead,
  output var  logic [15:0] hostDataIn,
  input  wire logic        hostAck,
  input  wire logic [15:0] hostDataOut,
  input  wire logic        hostDataOe
);
  initial {address_phase_strobe, hostReq, hostRead, hostDataIn} = 19'h0;
  task automatic waitAck(input logic v);
    for (int i = 0; i < 40 && hostAck !== v; i++) @(negedge sys_clk);
  endtask
  task automatic rd(input logic [2:0] a, output logic [15:0] d, output logic oe);
    @(negedge sys_clk);
    address_phase_strobe = 1'b1;
    hostDataIn = {13'h0000, a};
    @(negedge sys_clk);
    hostReq = 1'b1;
    waitAck(1'b1);
    hostReq = 1'b0;
    waitAck(1'b0);
    address_phase_strobe = 1'b0;
    hostDataIn = ~hostDataIn;
    hostRead = 1'b1;
    @(negedge sys_clk);
    hostReq = 1'b1;
    waitAck(1'b1);
    d = hostDataOut;
    oe = hostDataOe;
    hostReq = 1'b0;
    waitAck(1'b0);
    hostRead = 1'b0;
  endtask
endmodule
`default_nettype wire

// ### rwf_reading_word_formatter.v
// reading word formatter: packs readings into a buffer and serves them to the host
`timescale 1ns/1ps
`default_nettype none
`include "rwf_consts.vh"

module rwf_reading_word_formatter #(
  parameter                  DEPTH_LOG2 = 13,
  parameter [15:0]           IDENT_WORD = 16'h0040
) (
  input  wire                sys_clk,
  input  wire                srst,
  input  wire                rdgStore,
  input  wire                rdgGood,
  input  wire                rdgNegative,
  input  wire                rdgOverload,
  input  wire [15:0]         rdgMagnitude,
  input  wire [1:0]          rangeCode,
  input  wire                resetCmd,
  input  wire                resolSet,
  input  wire [1:0]          resolCode,
  input  wire                slot_register_read_command,
  input  wire [2:0]          cmdRegAddr,
  output reg  [15:0]         cmdReadData,
  output reg                 cmdReadDone,
  input  wire                address_phase_strobe,
  input  wire                hostReq,
  input  wire                hostRead,
  input  wire [15:0]         hostDataIn,
  output reg  [15:0]         hostDataOut,
  output wire                hostDataOe,
  output reg                 hostAck,
  output wire                bufferDropped,
  output reg  [1:0]          resolMode
);

  // IDENT_WORD default is arbitrary
  localparam DEPTH = 1 << DEPTH_LOG2;

  // parallel port handshake states
  localparam [1:0] HS_IDLE = `RWF_HS_IDLE;
  localparam [1:0] HS_HOLD = `RWF_HS_HOLD;
  localparam [1:0] HS_WAIT = `RWF_HS_WAIT;

  // two's complement of a count; its low bits serve the narrower layout
  function [15:0] negCount;
    input [15:0] cnt;
    begin
      negCount = ~cnt + 16'h0001;
    end
  endfunction

  // next buffer pointer; the top bit counts laps for the full test
  function [DEPTH_LOG2:0] ptrNext;
    input [DEPTH_LOG2:0] p;
    begin
      ptrNext = p + {{DEPTH_LOG2{1'b0}}, 1'b1};
    end
  endfunction

  // packs one reading for the given layout
  function [15:0] packWord;
    input [1:0]  mode;
    input        good;
    input        neg;
    input        ovl;
    input [15:0] mag;
    input [1:0]  rng;
    reg   [13:0] v14;
    reg   [15:0] v16;
    begin
      v16      = neg ? negCount(mag) : mag;
      v14      = v16[`RWF_R14_VAL_HI:0];
      packWord = `RWF_ZERO_WORD;
      case (mode)
        `RWF_MODE_14: begin
          if (ovl) begin
            v14 = neg ? `RWF_R14_NEG_OVL : `RWF_R14_POS_OVL;
          end
          packWord[`RWF_R14_RANGE_HI:`RWF_R14_RANGE_LO] = rng;
          packWord[`RWF_R14_VAL_HI:0]                   = v14;
        end
        `RWF_MODE_16: begin
          if (ovl) begin
            v16 = neg ? `RWF_R16_NEG_OVL : `RWF_R16_POS_OVL;
          end
          packWord = v16;
        end
        default: begin
          packWord[`RWF_GOOD_BIT]                       = good;
          packWord[`RWF_R13_RANGE_HI:`RWF_R13_RANGE_LO] = rng;
          packWord[`RWF_R13_SIGN_BIT]                   = ~neg;
          if (ovl) begin
            packWord[`RWF_R13_MAG_HI:0] = `RWF_R13_OVL;
          end else begin
            packWord[`RWF_R13_MAG_HI:0] = mag[`RWF_R13_MAG_HI:0];
          end
        end
      endcase
    end
  endfunction

  // register read value other than the data port
  function [15:0] plainRead;
    input [2:0]  addr;
    input [1:0]  rng;
    input        avail;
    reg   [15:0] s;
    begin
      s = `RWF_ZERO_WORD;
      s[`RWF_ST_RANGE_LO+1:`RWF_ST_RANGE_LO] = rng;
      s[`RWF_ST_AVAIL_BIT] = avail;
      case (addr)
        `RWF_ADDR_IDENT:  plainRead = IDENT_WORD;
        `RWF_ADDR_STATUS: plainRead = s;
        default:          plainRead = `RWF_ZERO_WORD;
      endcase
    end
  endfunction

  // reading buffer
  reg  [15:0]           bufMem [0:DEPTH-1];
  reg  [DEPTH_LOG2:0]   wrPtr;
  reg  [DEPTH_LOG2:0]   rdPtr;
  wire                  bufEmpty = (wrPtr == rdPtr);
  wire                  bufFull  = (wrPtr[DEPTH_LOG2-1:0] == rdPtr[DEPTH_LOG2-1:0]) &&
                                   (wrPtr[DEPTH_LOG2] != rdPtr[DEPTH_LOG2]);
  wire [15:0]           bufHead  = bufMem[rdPtr[DEPTH_LOG2-1:0]];

  // host pins pass two flops
  reg                   strobeMeta;
  reg                   strobeSync;
  reg                   reqMeta;
  reg                   reqSync;
  reg                   readMeta;
  reg                   readSync;
  reg  [15:0]           dataMeta;
  reg  [15:0]           dataSync;

  // cleared so that no stale request is seen right after reset
  always @(posedge sys_clk) begin
    if (srst) begin
      strobeMeta <= 1'b0;
      strobeSync <= 1'b0;
      reqMeta    <= 1'b0;
      reqSync    <= 1'b0;
      readMeta   <= 1'b0;
      readSync   <= 1'b0;
      dataMeta   <= `RWF_ZERO_WORD;
      dataSync   <= `RWF_ZERO_WORD;
    end else begin
      strobeMeta <= address_phase_strobe;
      strobeSync <= strobeMeta;
      reqMeta    <= hostReq;
      reqSync    <= reqMeta;
      readMeta   <= hostRead;
      readSync   <= readMeta;
      dataMeta   <= hostDataIn;
      dataSync   <= dataMeta;
    end
  end

  // resolution mode
  always @(posedge sys_clk) begin
    if (srst || resetCmd) begin
      resolMode <= `RWF_MODE_13;
    end else if (resolSet && resolCode != `RWF_MODE_BAD) begin
      resolMode <= resolCode;
    end
  end

  // a reading that meets a full buffer is lost and flagged for one cycle
  assign bufferDropped = rdgStore && bufFull;

  // store each reading packed by the mode in force now
  always @(posedge sys_clk) begin
    if (rdgStore && !bufFull) begin
      bufMem[wrPtr[DEPTH_LOG2-1:0]] <= packWord(resolMode, rdgGood, rdgNegative,
                                                rdgOverload, rdgMagnitude, rangeCode);
    end
  end

  // command port: a read pending until answered
  reg                   cmdPending;
  reg  [2:0]            cmdAddr;
  wire [2:0]            cmdAddrNow = slot_register_read_command ? cmdRegAddr : cmdAddr;
  wire                  cmdActive  = slot_register_read_command || cmdPending;
  wire                  cmdIsData  = (cmdAddrNow == `RWF_ADDR_DATA);
  wire                  cmdServe   = cmdActive && !(cmdIsData && bufEmpty);
  wire                  cmdPop     = cmdServe && cmdIsData;

  // parallel port handshake
  reg  [1:0]            hsState;
  reg  [2:0]            hostAddr;
  reg                   hostOe;
  wire                  hostIsData = (hostAddr == `RWF_ADDR_DATA);
  wire                  hostDataPh = (hsState == HS_IDLE || hsState == HS_WAIT) &&
                                     reqSync && !strobeSync && readSync;
  // command port has priority over the host for a pop
  wire                  hostServe  = hostDataPh && !(hostIsData && (bufEmpty || cmdPop));
  wire                  hostPop    = hostServe && hostIsData;

  assign hostDataOe = hostOe;

  always @(posedge sys_clk) begin
    if (srst) begin
      wrPtr <= {(DEPTH_LOG2+1){1'b0}};
      rdPtr <= {(DEPTH_LOG2+1){1'b0}};
    end else begin
      if (rdgStore && !bufFull) begin
        wrPtr <= ptrNext(wrPtr);
      end
      if (cmdPop || hostPop) begin
        rdPtr <= ptrNext(rdPtr);
      end
    end
  end

  // answer registered one cycle after the read is served
  always @(posedge sys_clk) begin
    if (srst) begin
      cmdPending  <= 1'b0;
      cmdAddr     <= `RWF_ADDR_IDENT;
      cmdReadDone <= 1'b0;
      cmdReadData <= `RWF_ZERO_WORD;
    end else begin
      cmdReadDone <= cmdServe;
      if (slot_register_read_command) begin
        cmdAddr <= cmdRegAddr;
      end
      cmdPending <= cmdActive && !cmdServe;
      if (cmdServe) begin
        cmdReadData <= cmdIsData ? bufHead : plainRead(cmdAddrNow, rangeCode, !bufEmpty);
      end
    end
  end

  always @(posedge sys_clk) begin
    if (srst) begin
      hsState     <= HS_IDLE;
      hostAddr    <= `RWF_ADDR_IDENT;
      hostAck     <= 1'b0;
      hostOe      <= 1'b0;
      hostDataOut <= `RWF_ZERO_WORD;
    end else begin
      case (hsState)
        HS_IDLE, HS_WAIT: begin
          if (reqSync && strobeSync) begin
            hostAddr <= dataSync[`RWF_ADDR_W-1:0];
            hostAck  <= 1'b1;
            hsState  <= HS_HOLD;
          end else if (reqSync && !readSync) begin
            // writes in the data phase are acked and dropped
            hostAck <= 1'b1;
            hsState <= HS_HOLD;
          end else if (hostServe) begin
            hostDataOut <= hostIsData ? bufHead : plainRead(hostAddr, rangeCode, !bufEmpty);
            hostOe      <= 1'b1;
            hostAck     <= 1'b1;
            hsState     <= HS_HOLD;
          end else if (hostDataPh) begin
            hsState <= HS_WAIT;
          end else begin
            hsState <= HS_IDLE;
          end
        end
        HS_HOLD: begin
          // answer stands until the host lets go of its request
          if (!reqSync) begin
            hostAck <= 1'b0;
            hostOe  <= 1'b0;
            hsState <= HS_IDLE;
          end
        end
        default: begin
          hsState <= HS_IDLE;
        end
      endcase
    end
  end

endmodule
`default_nettype wire

// ### tb.sv
// testbench for the reading word formatter
`timescale 1ns/1ps
`default_nettype none
module tb;
  localparam [15:0] ID = 16'h0040; // arbitrary
  logic        sys_clk = 1'b0, srst = 1'b1, rdgStore = 1'b0, rdgGood = 1'b0, rdgNegative = 1'b0;
  logic        rdgOverload = 1'b0, resetCmd = 1'b0, resolSet = 1'b0, slot_register_read_command = 1'b0;
  logic [15:0] rdgMagnitude = 16'h0000, cmdReadData, hostDataIn, hostDataOut, d;
  logic [1:0]  rangeCode = 2'h0, resolCode = 2'h0, resolMode;
  logic [2:0]  cmdRegAddr = 3'h0;
  logic        cmdReadDone, address_phase_strobe, hostReq, hostRead, hostDataOe, hostAck, bufferDropped, seen, oe;
  int          nErrors = 0, totalChecks = 0;
  logic [43:0] rows [11] = '{44'h0_8_0123_2_D123, 44'h0_4_0ABC_1_2ABC, 44'h0_E_0000_0_8FFF,
    44'h1_8_0100_3_C100, 44'h1_C_0001_1_7FFF, 44'h1_A_0000_2_9FFF, 44'h1_E_0000_0_2000,
    44'h2_8_1234_3_1234, 44'h2_C_0002_0_FFFE, 44'h2_A_0000_1_7FFF, 44'h2_E_0000_2_8000};
  always #20 sys_clk = ~sys_clk;
  rwf_reading_word_formatter #(.DEPTH_LOG2(3), .IDENT_WORD(ID)) dut (.sys_clk, .srst, .rdgStore, .rdgGood,
    .rdgNegative, .rdgOverload, .rdgMagnitude, .rangeCode, .resetCmd, .resolSet, .resolCode,
    .slot_register_read_command, .cmdRegAddr, .cmdReadData, .cmdReadDone, .address_phase_strobe, .hostReq,
    .hostRead, .hostDataIn, .hostDataOut, .hostDataOe, .hostAck, .bufferDropped, .resolMode);
  rwf_host_model host (.sys_clk, .address_phase_strobe, .hostReq, .hostRead, .hostDataIn, .hostAck, .hostDataOut,
    .hostDataOe);
  task automatic check(input logic [15:0] g, input logic [15:0] e);
    totalChecks++;
    if (g !== e) begin
      nErrors++;
      $display("Error at %0t: got %h expected %h", $time, g, e);
    end
  endtask
  task automatic printVerdict;
    $display("checks %0d errors %0d", totalChecks, nErrors);
    if (nErrors == 0 && totalChecks > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  task automatic store(input logic [43:0] r);
    @(negedge sys_clk);
    {rdgGood, rdgNegative, rdgOverload} = r[39:37];
    rdgMagnitude = r[35:20];
    rangeCode = r[17:16];
    rdgStore = 1'b1;
    @(negedge sys_clk);
    rdgStore = 1'b0;
  endtask
  task automatic setMode(input logic [1:0] m);
    @(negedge sys_clk);
    resolCode = m;
    resolSet = 1'b1;
    @(negedge sys_clk);
    resolSet = 1'b0;
  endtask
  task automatic cmdGo(input logic [2:0] a);
    @(negedge sys_clk);
    cmdRegAddr = a;
    slot_register_read_command = 1'b1;
    @(negedge sys_clk);
    slot_register_read_command = 1'b0;
  endtask
  task automatic cmdWait(output logic [15:0] v);
    for (int i = 0; i < 40 && cmdReadDone !== 1'b1; i++) @(negedge sys_clk);
    v = cmdReadData;
  endtask
  initial begin
    repeat (2) @(negedge sys_clk);
    srst = 1'b0;
    check({14'h0000, resolMode}, 16'h0000);
    for (int k = 0; k < 11; k++) begin
      setMode(rows[k][41:40]);
      store(rows[k]);
      cmdGo(3'h4);
      cmdWait(d);
      check(d, rows[k][15:0]);
    end
    $display("layout rows done");
    cmdGo(3'h0);
    cmdWait(d);
    check(d, ID);
    cmdGo(3'h1);
    cmdWait(d);
    check({14'h0000, d[9:8]}, 16'h0002);
    cmdGo(3'h4);
    seen = 1'b0;
    repeat (8) @(negedge sys_clk) seen |= cmdReadDone;
    check({15'h0000, seen}, 16'h0000);
    store(rows[7]);
    cmdWait(d);
    check(d, 16'h1234);
    $display("register and stall tests done");
    store(rows[8]);
    @(negedge sys_clk) resetCmd = 1'b1;
    @(negedge sys_clk) resetCmd = 1'b0;
    check({14'h0000, resolMode}, 16'h0000);
    host.rd(3'h4, d, oe);
    check(d, 16'hFFFE);
    check({15'h0000, oe}, 16'h0001);
    check({15'h0000, hostDataOe}, 16'h0000);
    $display("host port test done");
    setMode(2'h1);
    setMode(2'h3);
    check({14'h0000, resolMode}, 16'h0001);
    store(rows[3]);
    repeat (7) store(rows[3]);
    @(negedge sys_clk) rdgStore = 1'b1;
    #1 check({15'h0000, bufferDropped}, 16'h0001);
    @(negedge sys_clk) rdgStore = 1'b0;
    $display("full buffer test done");
    @(negedge sys_clk) srst = 1'b1;
    repeat (2) @(negedge sys_clk);
    srst = 1'b0;
    check({14'h0000, resolMode}, 16'h0000);
    cmdGo(3'h1);
    cmdWait(d);
    check({15'h0000, d[6]}, 16'h0000);
    $display("reset test done");
    printVerdict();
  end
  initial begin
    #400000;
    nErrors++;
    printVerdict();
  end
endmodule
bind rwf_reading_word_formatter rwf_fmt_asserts #(.IDENT_WORD(IDENT_WORD)) chk (.sys_clk, .srst,
  .slot_register_read_command, .cmdRegAddr, .cmdReadData, .cmdReadDone, .rangeCode, .resetCmd, .resolSet,
  .resolCode, .resolMode, .hostReq, .hostAck);
`default_nettype wire
